// ---- hdl/bcc_pkg.sv ----
// Package with control vector layout, symbol table and carrier types for the classifier
// Behaviour
// - Instruction run: run 0, phase 1, reset 1
// - Stall retry: run/phase 1, enable 0, busy 1
// - Fixup read: run/phase 1, exception 0, enable 0
// - Fixup: run/phase 1, exception 0, reset 1
// - Stall: run/phase 1, exception 1, reset 1
// - Uncached fetch: phase 1, enable 0, writes 1
// - Main memory fetch: phase 1, enable 0, reset 1
// - Data run byte read: access type 000
// - Half-word read 001; tribyte read 010
// - Data run word read: access type 011
// - Data run cache read: any access type
package bcc_pkg;

  // Width of the sampled control vector
  localparam int CTRL_W = 16;

  // Bit positions inside the control vector, most significant first
  localparam int POS_RUN = 15;
  localparam int POS_PHASE = 14;
  localparam int POS_EXC = 13;
  localparam int POS_MEM_EN = 12;
  localparam int POS_IRD = 11;
  localparam int POS_IWR = 10;
  localparam int POS_DRD = 9;
  localparam int POS_DWR = 8;
  localparam int POS_MRD = 7;
  localparam int POS_MWR = 6;
  localparam int POS_RBUSY = 5;
  localparam int POS_WBUSY = 4;
  localparam int POS_RESET = 3;
  localparam int POS_ACC_HI = 2;

  // Number of symbol patterns in the table
  localparam int NUM_SYM = 12;

  // Symbol codes; code zero means no pattern matched
  typedef enum logic [3:0] {
    SYM_NONE = 4'h0,
    SYM_INSTR_RUN = 4'h1,
    SYM_STALL_RETRY = 4'h2,
    SYM_FIXUP_READ = 4'h3,
    SYM_FIXUP = 4'h4,
    SYM_STALL = 4'h5,
    SYM_UNCACHED = 4'h6,
    SYM_MAIN_MEM = 4'h7,
    SYM_RD_BYTE = 4'h8,
    SYM_RD_HALF = 4'h9,
    SYM_RD_TRI = 4'hA,
    SYM_RD_WORD = 4'hB,
    SYM_RD_CACHE = 4'hC
  } bcc_symbol_type;

  // Care masks, in table order; a set bit takes part in the comparison
  localparam logic [NUM_SYM-1:0][CTRL_W-1:0] SYM_MASK = {
    16'hC208, // Data cache read, any access type
    16'hC20F, // Word read
    16'hC20F, // Tribyte read
    16'hC20F, // Half-word read
    16'hC20F, // Byte read
    16'h5008, // Main memory fetch
    16'h5508, // Uncached fetch
    16'hE008, // Stall
    16'hE008, // Fixup
    16'hF008, // Fixup read
    16'hD028, // Stall with retry
    16'hC008  // Instruction run
  };

  // Expected values under the care masks, in table order
  localparam logic [NUM_SYM-1:0][CTRL_W-1:0] SYM_VALUE = {
    16'h0008,
    16'h000B,
    16'h000A,
    16'h0009,
    16'h0008,
    16'h4008,
    16'h4508,
    16'hE008,
    16'hC008,
    16'hC008,
    16'hC028,
    16'h4008
  };

  // Read size encodings in bytes
  localparam logic [2:0] SIZE_NONE = 3'h0;
  localparam logic [2:0] SIZE_BYTE = 3'h1;
  localparam logic [2:0] SIZE_HALF = 3'h2;
  localparam logic [2:0] SIZE_TRI = 3'h3;
  localparam logic [2:0] SIZE_WORD = 3'h4;

  // Stages of the pin synchroniser
  localparam int SYNC_STAGES = 2;

  // Sampled processor control pins, active-low ones marked _n
  typedef struct packed {
    logic run_stall;
    logic phase;
    logic exception_n;
    logic main_memory_enable_n;
    logic instr_cache_read_n;
    logic instr_cache_write_n;
    logic data_cache_read_n;
    logic data_cache_write_n;
    logic memory_read_n;
    logic memory_write_n;
    logic read_busy_n;
    logic write_busy_n;
    logic cpu_reset_n;
    logic access_type_b2;
    logic access_type_b1;
    logic access_type_b0;
  } bcc_pins_type;

  // Classification result handed to display or trigger logic
  typedef struct packed {
    bcc_symbol_type symbol;
    logic instr_phase;
    logic data_phase;
    logic stalled;
    logic main_memory;
    logic [2:0] read_size;
    logic multi_match;
  } bcc_class_type;

  // Reset values of the result
  localparam bcc_class_type CLASS_RESET = '{
    symbol: SYM_NONE,
    instr_phase: 1'b0,
    data_phase: 1'b0,
    stalled: 1'b0,
    main_memory: 1'b0,
    read_size: SIZE_NONE,
    multi_match: 1'b0
  };

endpackage

// ---- hdl/bcc_sync.sv ----
// Two-flop synchroniser for a group of pin inputs
`timescale 1ns/1ns
module bcc_sync #(
  parameter int WIDTH = 16,
  parameter int STAGES = 2
) (
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst_n,
  // Asynchronous input and its synchronised copy
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);

  // Stage chain; only the next stage reads each stage
  logic [STAGES-1:0][WIDTH-1:0] stage_q;

  // Refuse chains too short to settle metastability, at elaboration
  if (STAGES < 2 || WIDTH < 1)
  begin : g_bad_config
    $error("bcc_sync needs at least two stages and one bit");
  end

  // Shift the pins through the chain, cleared by reset
  always_ff @(posedge core_clk)
  begin
    if (!rst_n)
    begin
      stage_q <= '0;
    end
    else
    begin
      stage_q <= {stage_q[STAGES-2:0], async_in};
    end
  end

  // Last stage is the only one logic may read
  assign sync_out = stage_q[STAGES-1];

endmodule

// ---- hdl/bcc_classifier.sv ----
// Bus cycle classifier: names the cycle type of each sampled control vector
`timescale 1ns/1ns
module bcc_classifier (
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst_n,
  // Processor control pins, sampled from outside the clock domain
  input wire bcc_pkg::bcc_pins_type pins,
  // Classification result
  output bcc_pkg::bcc_class_type class_q,
  output logic [bcc_pkg::NUM_SYM-1:0] match_q,
  output logic [bcc_pkg::CTRL_W-1:0] vector_q,
  output logic valid_q
);
  import bcc_pkg::*;

  // Pins as a flat word, synchronised copy, and the assembled vector
  logic [CTRL_W-1:0] pins_raw;
  logic [CTRL_W-1:0] pins_sync;
  logic [CTRL_W-1:0] ctrl_vec;
  // Match vector of the current sample
  logic [NUM_SYM-1:0] hits;
  // Result of the current sample before registering
  bcc_class_type class_d;
  // Pipeline fill counter for the valid flag
  logic [1:0] fill_q;

  // Order the pins into the control vector, run/stall highest
  always_comb
  begin
    pins_raw = '0;
    pins_raw[POS_RUN] = pins.run_stall;
    pins_raw[POS_PHASE] = pins.phase;
    pins_raw[POS_EXC] = pins.exception_n;
    pins_raw[POS_MEM_EN] = pins.main_memory_enable_n;
    pins_raw[POS_IRD] = pins.instr_cache_read_n;
    pins_raw[POS_IWR] = pins.instr_cache_write_n;
    pins_raw[POS_DRD] = pins.data_cache_read_n;
    pins_raw[POS_DWR] = pins.data_cache_write_n;
    pins_raw[POS_MRD] = pins.memory_read_n;
    pins_raw[POS_MWR] = pins.memory_write_n;
    pins_raw[POS_RBUSY] = pins.read_busy_n;
    pins_raw[POS_WBUSY] = pins.write_busy_n;
    pins_raw[POS_RESET] = pins.cpu_reset_n;
    pins_raw[POS_ACC_HI] = pins.access_type_b2;
    pins_raw[POS_ACC_HI-1] = pins.access_type_b1;
    pins_raw[POS_ACC_HI-2] = pins.access_type_b0;
  end

  // Pins come from the processor, so they cross two flops first
  bcc_sync #(
    .WIDTH(CTRL_W),
    .STAGES(SYNC_STAGES)
  ) u_sync (
    .core_clk(core_clk),
    .rst_n(rst_n),
    .async_in(pins_raw),
    .sync_out(pins_sync)
  );

  assign ctrl_vec = pins_sync;

  // Compare one vector against one masked pattern
  function automatic logic pattern_hit(input logic [CTRL_W-1:0] vec,
                                       input logic [CTRL_W-1:0] mask,
                                       input logic [CTRL_W-1:0] value);
    pattern_hit = ((vec & mask) == value);
  endfunction

  // Index of the first set hit, plus one; zero when none
  function automatic logic [3:0] first_hit(input logic [NUM_SYM-1:0] h);
    logic [3:0] idx;
    idx = 4'h0;
    for (int i = NUM_SYM - 1; i >= 0; i--)
    begin
      if (h[i])
      begin
        idx = 4'(i + 1);
      end
    end
    first_hit = idx;
  endfunction

  // Read size in bytes implied by a data-side symbol
  function automatic logic [2:0] size_of(input bcc_symbol_type s);
    logic [2:0] sz;
    sz = SIZE_NONE;
    unique case (s)
      SYM_RD_BYTE: sz = SIZE_BYTE;
      SYM_RD_HALF: sz = SIZE_HALF;
      SYM_RD_TRI: sz = SIZE_TRI;
      SYM_RD_WORD: sz = SIZE_WORD;
      default: sz = SIZE_NONE;
    endcase
    size_of = sz;
  endfunction

  // Test every pattern; masks leave ignored bits out of the compare
  always_comb
  begin
    hits = '0;
    for (int i = 0; i < NUM_SYM; i++)
    begin
      // Instruction run, retry, fixup, stall, fetch and data read rows
      hits[i] = pattern_hit(ctrl_vec, SYM_MASK[i], SYM_VALUE[i]);
    end
  end

  // Pick the first matching row and derive the summary flags
  always_comb
  begin
    class_d = CLASS_RESET;
    // Earlier rows win over later ones, however few bits their masks compare
    class_d.symbol = bcc_symbol_type'(first_hit(hits));
    class_d.multi_match = ($countones(hits) > 1);
    class_d.read_size = size_of(class_d.symbol);
    unique case (class_d.symbol)
      // Instruction-side symbols
      SYM_INSTR_RUN:
      begin
        class_d.instr_phase = 1'b1;
      end
      SYM_STALL_RETRY:
      begin
        class_d.instr_phase = 1'b1;
        class_d.stalled = 1'b1;
        class_d.main_memory = 1'b1;
      end
      SYM_FIXUP_READ:
      begin
        class_d.instr_phase = 1'b1;
        class_d.stalled = 1'b1;
        class_d.main_memory = 1'b1;
      end
      SYM_FIXUP:
      begin
        class_d.instr_phase = 1'b1;
        class_d.stalled = 1'b1;
      end
      SYM_STALL:
      begin
        class_d.instr_phase = 1'b1;
        class_d.stalled = 1'b1;
      end
      SYM_UNCACHED:
      begin
        class_d.instr_phase = 1'b1;
        class_d.main_memory = 1'b1;
      end
      SYM_MAIN_MEM:
      begin
        class_d.instr_phase = 1'b1;
        class_d.main_memory = 1'b1;
      end
      // Data-side reads from the data cache
      SYM_RD_BYTE, SYM_RD_HALF, SYM_RD_TRI, SYM_RD_WORD:
      begin
        class_d.data_phase = 1'b1;
      end
      SYM_RD_CACHE:
      begin
        class_d.data_phase = 1'b1;
      end
      // No row matched
      default:
      begin
        class_d.instr_phase = 1'b0;
      end
    endcase
  end

  // Register the result once per sampling clock
  always_ff @(posedge core_clk)
  begin
    if (!rst_n)
    begin
      class_q <= CLASS_RESET;
      match_q <= '0;
      vector_q <= '0;
    end
    else
    begin
      class_q <= class_d;
      match_q <= hits;
      vector_q <= ctrl_vec;
    end
  end

  // Valid rises once the synchroniser holds real samples
  always_ff @(posedge core_clk)
  begin
    if (!rst_n)
    begin
      fill_q <= 2'h0;
      valid_q <= 1'b0;
    end
    else
    begin
      if (fill_q != 2'h2)
      begin
        fill_q <= fill_q + 2'h1;
      end
      valid_q <= (fill_q == 2'h2);
    end
  end

endmodule

// ---- verif/bcc_cpu_model.sv ----
// Processor side model that drives the sampled control pins
`timescale 1ns/1ns
module bcc_cpu_model (
  // Control vector requested by the bench
  input wire logic [bcc_pkg::CTRL_W-1:0] vec_req,
  // Pins as the processor drives them
  output bcc_pkg::bcc_pins_type pins
);
  import bcc_pkg::*;

  // Pins start low, then settle a few ns after each request, away from the edge
  initial
  begin
    pins = '0;
    forever
    begin
      @(vec_req);
      pins <= #3 bcc_pins_type'(vec_req);
    end
  end
endmodule

// ---- verif/bcc_classifier_chk.sv ----
// Checker of the classifier's port relations
`timescale 1ns/1ns
module bcc_classifier_chk (
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst_n,
  // Watched ports
  input wire bcc_pkg::bcc_pins_type pins,
  input wire bcc_pkg::bcc_class_type class_q,
  input wire logic [bcc_pkg::NUM_SYM-1:0] match_q,
  input wire logic [bcc_pkg::CTRL_W-1:0] vector_q,
  input wire logic valid_q
);
  import bcc_pkg::*;

  // One clock domain, reset kills every attempt
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!rst_n);

  // Reset has been released long enough to fill the pipeline
  sequence s_settled;
    rst_n [*4];
  endsequence

  a_vector_lag: assert property (s_settled |-> vector_q == $past(pins, 3))
    else $error("vector does not follow pins");
  a_valid_up: assert property (s_settled |-> valid_q)
    else $error("valid missing after fill");
  a_run_sym: assert property ((vector_q[15:14] == 2'b01 && vector_q[3]) |->
    class_q.symbol == SYM_INSTR_RUN) else $error("run cycle misnamed");
  a_retry_sym: assert property (((vector_q & 16'hD028) == 16'hC028) |->
    class_q.symbol == SYM_STALL_RETRY) else $error("stall retry misnamed");
  a_fixup_read: assert property (((vector_q & 16'hF028) == 16'hC008) |->
    class_q.symbol == SYM_FIXUP_READ) else $error("fixup read misnamed");
  a_fixup_sym: assert property (((vector_q & 16'hF008) == 16'hD008) |->
    class_q.symbol == SYM_FIXUP) else $error("fixup misnamed");
  a_stall_sym: assert property (((vector_q & 16'hE028) == 16'hE008 ||
    (vector_q & 16'hF008) == 16'hF008) |-> class_q.symbol == SYM_STALL)
    else $error("stall misnamed");
  a_fetch_hits: assert property (((vector_q & 16'h5508) == 16'h4508) |->
    match_q[6:5] == 2'b11) else $error("fetch rows not hit");
  a_data_read: assert property (((vector_q & 16'hC208) == 16'h0008) |->
    class_q.symbol == (vector_q[2] ? SYM_RD_CACHE :
    bcc_symbol_type'(4'h8 + {2'h0, vector_q[1:0]}))) else $error("data read misnamed");
  a_no_match: assert property ((match_q == '0) |-> class_q.symbol == SYM_NONE)
    else $error("symbol without a hit");
endmodule

bind bcc_classifier bcc_classifier_chk u_chk (
  .core_clk(core_clk),
  .rst_n(rst_n),
  .pins(pins),
  .class_q(class_q),
  .match_q(match_q),
  .vector_q(vector_q),
  .valid_q(valid_q)
);

// ---- verif/test_bcc_classifier.sv ----
// Self-checking bench for the bus cycle classifier
`timescale 1ns/1ns
module test_bcc_classifier;
  import bcc_pkg::*;

  // Row: vector, expected symbol code, expected row hits
  typedef struct packed {logic [15:0] vec; logic [3:0] sym; logic [11:0] hit;} bcc_row_type;
  localparam int N_ROWS = 17;
  localparam bcc_row_type ROWS [N_ROWS] = '{
    '{16'h4008, 4'h1, 12'h041},
    '{16'h7FFF, 4'h1, 12'h001},
    '{16'hC028, 4'h2, 12'h04E},
    '{16'hC008, 4'h3, 12'h04C},
    '{16'hD008, 4'h4, 12'h008},
    '{16'hE008, 4'h5, 12'h050},
    '{16'hF008, 4'h5, 12'h010},
    '{16'h4508, 4'h1, 12'h061},
    '{16'hE508, 4'h5, 12'h070},
    '{16'h0008, 4'h8, 12'h880},
    '{16'h0009, 4'h9, 12'h900},
    '{16'h000A, 4'hA, 12'hA00},
    '{16'h000B, 4'hB, 12'hC00},
    '{16'h000C, 4'hC, 12'h800},
    '{16'h0208, 4'h0, 12'h000},
    '{16'h4000, 4'h0, 12'h000},
    '{16'h0000, 4'h0, 12'h000}
  };

  // Clock, reset and stimulus
  logic core_clk;
  logic rst_n;
  logic [15:0] vec_req;
  // Design pins and outputs
  bcc_pins_type pins;
  bcc_class_type class_q;
  logic [11:0] match_q;
  logic [15:0] vector_q;
  logic valid_q;
  // Score and watchdog counters
  int n_mismatch = 0;
  int tests_run = 0;
  int cycle_count = 0;

  bcc_cpu_model u_cpu (.vec_req(vec_req), .pins(pins));
  bcc_classifier uut (.core_clk(core_clk), .rst_n(rst_n), .pins(pins),
    .class_q(class_q), .match_q(match_q), .vector_q(vector_q), .valid_q(valid_q));

  // 50 MHz clock
  initial core_clk = 1'b0;
  always #10 core_clk = ~core_clk;

  // Summary flags follow from the symbol code, multi-match from the row hits
  function automatic bcc_class_type exp_class(input logic [3:0] s, input logic [11:0] h);
    bcc_class_type c;
    c.symbol = bcc_symbol_type'(s);
    c.instr_phase = (s >= 4'h1) && (s <= 4'h7);
    c.data_phase = s >= 4'h8;
    c.stalled = (s >= 4'h2) && (s <= 4'h5);
    c.main_memory = (s == 4'h2) || (s == 4'h3) || (s == 4'h6) || (s == 4'h7);
    c.read_size = (s >= 4'h8 && s <= 4'hB) ? 3'(s - 4'h7) : 3'h0;
    c.multi_match = (h & (h - 12'h001)) != 12'h000;
    return c;
  endfunction

  // Compares one value and reports a difference
  task automatic chk_val(input string what, input logic [15:0] exp, input logic [15:0] got);
    tests_run++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask

  // Compares the vector, match and class outputs against one table row
  task automatic chk_row(input bcc_row_type r);
    chk_val("vector", r.vec, vector_q);
    chk_val("match", {4'h0, r.hit}, {4'h0, match_q});
    chk_val("class", {4'h0, exp_class(r.sym, r.hit)}, {4'h0, class_q});
  endtask

  // Verdict and end of run
  task automatic tally_and_finish();
    if (n_mismatch == 0 && tests_run > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  // Watchdog against a hung run
  always @(posedge core_clk)
  begin
    cycle_count++;
    if (cycle_count == 200)
    begin
      n_mismatch++;
      tally_and_finish();
    end
  end

  initial
  begin
    rst_n = 1'b0;
    vec_req = 16'h0000;
    // Reset held for ten cycles, outputs cleared meanwhile
    repeat (10) @(posedge core_clk);
    rst_n <= 1'b1;
    #1;
    chk_val("reset vector", 16'h0000, vector_q);
    chk_val("reset valid", 16'h0000, {15'h0000, valid_q});
    // Rows streamed back to back, each seen three edges later
    for (int i = 0; i < N_ROWS + 3; i++)
    begin
      @(posedge core_clk);
      if (i < N_ROWS)
        vec_req <= ROWS[i].vec;
      #1;
      if (i >= 3)
        chk_row(ROWS[i - 3]);
    end
    // Reset in mid-run clears a pipeline that holds a real sample
    @(posedge core_clk);
    vec_req <= ROWS[2].vec;
    repeat (3) @(posedge core_clk);
    rst_n <= 1'b0;
    #1;
    chk_row(ROWS[2]);
    @(posedge core_clk);
    #1;
    chk_row(ROWS[N_ROWS - 1]);
    chk_val("valid in reset", 16'h0000, {15'h0000, valid_q});
    @(posedge core_clk);
    rst_n <= 1'b1;
    @(posedge core_clk);
    #1;
    chk_val("valid early", 16'h0000, {15'h0000, valid_q});
    chk_val("vector early", 16'h0000, vector_q);
    repeat (2) @(posedge core_clk);
    #1;
    chk_val("valid filled", 16'h0001, {15'h0000, valid_q});
    chk_row(ROWS[2]);
    tally_and_finish();
  end
endmodule
